// ---- design/program_flash_self_update.sv ----
// Function
// R1: Each table read returns one program byte into the table latch.
// R2: Table read loads latch and optionally adjusts pointer for next access.
// R3: Memory is 16-bit words; pointer bit 0 selects high or low byte.
// R4: Self erase always clears one 64-byte block; no word or bulk erase.
// R5: Erase block chosen by pointer bits 21:6; bits 5:0 ignored.
// R6: Software sets program space, clears config space, enables write, selects erase.
// R7: Start accepted only after 55h then AAh to unlock port, then start.
// R8: Start with erase select and valid unlock begins the row erase.
// R9: Core halted during long write; internal timer ends it.
// R10: Row erase stalls the core about 2 ms.
// R11: Programming always writes a block of 8 bytes.
// R12: Eight byte-wide holding registers loaded by table writes feed programming.
// R13: Table write only updates a holding register, never the array.
// R14: Software fills all eight holding registers with auto-increment writes first.
// R15: Software sets program space, clears config, enables write, erase select clear.
// R16: Start after unlock with erase select clear programs block, about 2 ms stall.
// R17: Pointer must lie inside the intended 8-byte block at start.
// R18: Row update is read, erase, then eight 8-byte programs, about 18 ms.
// R19: Start bit set only by software; hardware clears it at completion.
// R20: Table write uses pointer bits 2:0 to pick the holding register.
// R21: Program write uses pointer bits 21:3 to pick the 8-byte block.
// R22: Reset during a long write sets the write error flag.
// R23: Start without write enable or without fresh unlock leaves array untouched.
// R24: Erase select clears automatically when a row erase completes.
`timescale 1ns/100ps
`default_nettype none

module program_flash_self_update #(
    parameter int LONG_WRITE_CYCLES = program_flash_pkg::LONG_WRITE_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    // Core side
    input wire logic table_read_op_i,
    input wire logic table_write_op_i,
    input wire logic [1:0] ptr_mode_i,
    input wire logic table_pointer_wr_i,
    input wire logic [program_flash_pkg::PTR_W-1:0] table_pointer_wdata_i,
    input wire logic table_latch_wr_i,
    input wire logic [7:0] table_latch_wdata_i,
    input wire logic nvm_control_wr_i,
    input wire logic [7:0] nvm_control_wdata_i,
    input wire logic nvm_unlock_wr_i,
    input wire logic [7:0] nvm_unlock_wdata_i,
    output logic [program_flash_pkg::PTR_W-1:0] table_pointer_o,
    output logic [7:0] table_latch_o,
    output logic [7:0] nvm_control_reg_o,
    output logic write_error_flag_o,
    output logic core_stall_o,
    // Flash array side
    output logic flash_rd_en_o,
    output logic [program_flash_pkg::PTR_W-2:0] flash_rd_word_addr_o,
    input wire logic [15:0] flash_rd_data_i,
    output logic flash_erase_o,
    output logic flash_prog_o,
    output logic [program_flash_pkg::PTR_W-1:0] flash_op_addr_o,
    output logic [8*program_flash_pkg::HOLD_COUNT-1:0] flash_prog_data_o
);

    localparam int CNT_W = $clog2(LONG_WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(LONG_WRITE_CYCLES - 1);
    localparam int PW = program_flash_pkg::PTR_W;
    localparam int OW = program_flash_pkg::OFS_W;

    // ------------------------------------------------------------
    // Pointer arithmetic
    // ------------------------------------------------------------
    // Only the low 21 bits move; bit 21 (ID/config space) stays put.
    function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p, input logic up);
        logic [OW-1:0] lo;
        lo = up ? (p[OW-1:0] + OW'(1)) : (p[OW-1:0] - OW'(1));
        return {p[PW-1], lo};
    endfunction : ptr_step

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [PW-1:0] ptr_r;
    logic [PW-1:0] ptr_nxt;
    logic [7:0] latch_r;
    logic [7:0] latch_nxt;
    logic [7:0] hold_r [program_flash_pkg::HOLD_COUNT];
    logic pgm_space_r;
    logic cfg_space_r;
    logic row_erase_r;
    logic row_erase_nxt;
    logic wr_enable_r;
    logic wr_enable_nxt;
    logic wr_start_r;
    logic wr_start_nxt;
    logic wr_error_r;
    logic wr_error_nxt;
    program_flash_pkg::unlock_state_t ul_r;
    program_flash_pkg::unlock_state_t ul_nxt;
    program_flash_pkg::long_write_state_t lw_r;
    program_flash_pkg::long_write_state_t lw_nxt;
    logic [CNT_W-1:0] cnt_r;
    logic erase_pulse_r;
    logic prog_pulse_r;
    logic [PW-1:0] op_addr_r;

    // ------------------------------------------------------------
    // Decode of core requests
    // ------------------------------------------------------------
    program_flash_pkg::ptr_mode_t mode;
    wire busy = (lw_r != program_flash_pkg::LW_IDLE);
    wire table_op = (table_read_op_i | table_write_op_i) & ~busy;
    wire rd_go = table_read_op_i & ~busy;
    wire wt_go = table_write_op_i & ~busy;
    wire ctl_go = nvm_control_wr_i & ~busy;
    wire ul_go = nvm_unlock_wr_i & ~busy;
    wire any_access = table_op | ctl_go | ul_go | ((table_pointer_wr_i | table_latch_wr_i) & ~busy);
    wire [PW-1:0] ptr_plus = ptr_step(ptr_r, 1'b1);
    wire [PW-1:0] ptr_minus = ptr_step(ptr_r, 1'b0);
    wire [PW-1:0] eff_ptr = (mode == program_flash_pkg::PTR_PRE_INC) ? ptr_plus : ptr_r;
    wire [7:0] rd_byte = eff_ptr[0] ? flash_rd_data_i[15:8] : flash_rd_data_i[7:0]; // R3
    wire [program_flash_pkg::HOLD_IDX_W-1:0] hold_idx = eff_ptr[program_flash_pkg::HOLD_IDX_W-1:0]; // R20
    wire set_start = ctl_go & nvm_control_wdata_i[program_flash_pkg::CTL_WR_START];
    wire new_cfg = ctl_go ? nvm_control_wdata_i[program_flash_pkg::CTL_CFG_SPACE] : cfg_space_r;
    wire new_pgm = ctl_go ? nvm_control_wdata_i[program_flash_pkg::CTL_PGM_SPACE] : pgm_space_r;
    // Enable and erase select come from the starting write
    wire new_write_enable_bit = nvm_control_wdata_i[program_flash_pkg::CTL_WR_ENABLE];
    wire new_erase = nvm_control_wdata_i[program_flash_pkg::CTL_ROW_ERASE];
    wire start_ok = set_start & (ul_r == program_flash_pkg::UL_ARMED) & new_write_enable_bit & new_pgm & ~new_cfg; // R7 R23
    wire timer_done = busy & (cnt_r == CNT_LAST); // R9
    wire erase_start = start_ok & new_erase; // R8
    wire prog_start = start_ok & ~new_erase; // R16

    assign mode = program_flash_pkg::ptr_mode_t'(ptr_mode_i);

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------
    // Any other access disarms, so a stray instruction kills the start.
    always_comb begin
        ul_nxt = program_flash_pkg::UL_IDLE;
        unique case (ul_r)
            program_flash_pkg::UL_IDLE: begin
                if (ul_go && nvm_unlock_wdata_i == program_flash_pkg::UNLOCK_FIRST) begin
                    ul_nxt = program_flash_pkg::UL_FIRST; // R7
                end
            end
            program_flash_pkg::UL_FIRST: begin
                if (!any_access) begin
                    ul_nxt = program_flash_pkg::UL_FIRST;
                end else if (ul_go && nvm_unlock_wdata_i == program_flash_pkg::UNLOCK_SECOND) begin
                    ul_nxt = program_flash_pkg::UL_ARMED; // R7
                end else if (ul_go && nvm_unlock_wdata_i == program_flash_pkg::UNLOCK_FIRST) begin
                    ul_nxt = program_flash_pkg::UL_FIRST;
                end
            end
            program_flash_pkg::UL_ARMED: begin
                if (!any_access) begin
                    ul_nxt = program_flash_pkg::UL_ARMED;
                end else if (ul_go && nvm_unlock_wdata_i == program_flash_pkg::UNLOCK_FIRST) begin
                    ul_nxt = program_flash_pkg::UL_FIRST;
                end
            end
            default: ul_nxt = program_flash_pkg::UL_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Long write sequencer
    // ------------------------------------------------------------
    always_comb begin
        lw_nxt = lw_r;
        unique case (lw_r)
            program_flash_pkg::LW_IDLE: begin
                if (erase_start) begin
                    lw_nxt = program_flash_pkg::LW_ERASE; // R8
                end else if (prog_start) begin
                    lw_nxt = program_flash_pkg::LW_PROG; // R16
                end
            end
            program_flash_pkg::LW_ERASE,
            program_flash_pkg::LW_PROG: begin
                if (timer_done) begin
                    lw_nxt = program_flash_pkg::LW_IDLE; // R9 R10
                end
            end
            default: lw_nxt = program_flash_pkg::LW_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // Pointer, latch and control bit next values
    // ------------------------------------------------------------
    always_comb begin
        ptr_nxt = ptr_r;
        if (table_op) begin
            unique case (mode)
                program_flash_pkg::PTR_KEEP: ptr_nxt = ptr_r;
                program_flash_pkg::PTR_POST_INC: ptr_nxt = ptr_plus; // R2
                program_flash_pkg::PTR_POST_DEC: ptr_nxt = ptr_minus; // R2
                program_flash_pkg::PTR_PRE_INC: ptr_nxt = ptr_plus; // R2
            endcase
        end else if (table_pointer_wr_i && !busy) begin
            ptr_nxt = table_pointer_wdata_i;
        end
    end

    assign latch_nxt = rd_go ? rd_byte : ((table_latch_wr_i && !busy) ? table_latch_wdata_i : latch_r); // R1 R2

    // Start bit only ever set by software, cleared by the timer
    assign wr_start_nxt = timer_done ? 1'b0 : (start_ok ? 1'b1 : wr_start_r); // R19 R23
    assign row_erase_nxt = (timer_done && lw_r == program_flash_pkg::LW_ERASE) ? 1'b0 :
                           (ctl_go ? new_erase : row_erase_r); // R24
    assign wr_enable_nxt = ctl_go ? new_write_enable_bit : wr_enable_r;
    assign wr_error_nxt = ctl_go ? nvm_control_wdata_i[program_flash_pkg::CTL_WR_ERROR] : wr_error_r;

    // ------------------------------------------------------------
    // Registers cleared on every reset
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !por_n_i) begin
            ptr_r <= program_flash_pkg::PTR_RESET;
            latch_r <= program_flash_pkg::LATCH_RESET;
            row_erase_r <= 1'b0;
            wr_enable_r <= 1'b0;
            wr_start_r <= 1'b0;
            ul_r <= program_flash_pkg::UL_IDLE;
            lw_r <= program_flash_pkg::LW_IDLE;
        end else begin
            ptr_r <= ptr_nxt;
            latch_r <= latch_nxt;
            row_erase_r <= row_erase_nxt;
            wr_enable_r <= wr_enable_nxt;
            wr_start_r <= wr_start_nxt;
            ul_r <= ul_nxt;
            lw_r <= lw_nxt;
        end
    end

    // ------------------------------------------------------------
    // Registers kept over a warm reset
    // ------------------------------------------------------------
    // Space selects survive a warm reset so an aborted write can be traced.
    always_ff @(posedge ref_clk_i) begin
        if (!por_n_i) begin
            pgm_space_r <= 1'b0;
            cfg_space_r <= 1'b0;
            wr_error_r <= 1'b0;
        end else if (!rst_n_i) begin
            wr_error_r <= wr_error_r | busy; // R22
        end else begin
            pgm_space_r <= new_pgm;
            cfg_space_r <= new_cfg;
            wr_error_r <= wr_error_nxt;
        end
    end

    // ------------------------------------------------------------
    // Programming timer and array strobes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !por_n_i) begin
            cnt_r <= '0;
            erase_pulse_r <= 1'b0;
            prog_pulse_r <= 1'b0;
            op_addr_r <= program_flash_pkg::PTR_RESET;
        end else begin
            cnt_r <= busy ? (cnt_r + CNT_W'(1)) : '0; // R9 R10
            erase_pulse_r <= erase_start; // R4 R8
            prog_pulse_r <= prog_start; // R11 R16
            if (erase_start) begin
                op_addr_r <= {ptr_r[PW-1:program_flash_pkg::ERASE_LSB],
                              {program_flash_pkg::ERASE_LSB{1'b0}}}; // R5
            end else if (prog_start) begin
                op_addr_r <= {ptr_r[PW-1:program_flash_pkg::PROG_LSB],
                              {program_flash_pkg::PROG_LSB{1'b0}}}; // R21
            end
        end
    end

    // ------------------------------------------------------------
    // Holding registers
    // ------------------------------------------------------------
    // Reset to FFh after each program so stale bytes never reach the next block.
    genvar gi;
    generate
        for (gi = 0; gi < program_flash_pkg::HOLD_COUNT; gi++) begin : g_hold
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i || !por_n_i) begin
                    hold_r[gi] <= program_flash_pkg::HOLD_RESET;
                end else if (timer_done && lw_r == program_flash_pkg::LW_PROG) begin
                    hold_r[gi] <= program_flash_pkg::HOLD_RESET;
                end else if (wt_go && hold_idx == program_flash_pkg::HOLD_IDX_W'(gi)) begin
                    hold_r[gi] <= latch_r; // R12 R13 R20
                end
            end
            assign flash_prog_data_o[8*gi +: 8] = hold_r[gi]; // R11 R12
        end
    endgenerate

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign table_pointer_o = ptr_r;
    assign table_latch_o = latch_r;
    assign nvm_control_reg_o = {pgm_space_r, cfg_space_r, 1'b0, row_erase_r,
                                wr_error_r, wr_enable_r, wr_start_r, 1'b0};
    assign write_error_flag_o = wr_error_r;
    assign core_stall_o = busy; // R9
    assign flash_rd_en_o = rd_go; // R1
    assign flash_rd_word_addr_o = eff_ptr[PW-1:1]; // R3
    assign flash_erase_o = erase_pulse_r;
    assign flash_prog_o = prog_pulse_r;
    assign flash_op_addr_o = op_addr_r;

endmodule : program_flash_self_update

`default_nettype wire

// ---- inc/program_flash_pkg.sv ----
package program_flash_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PTR_W = 22;
    localparam int OFS_W = 21;
    localparam int HOLD_COUNT = 8;
    localparam int HOLD_IDX_W = 3;
    localparam int ERASE_LSB = 6;
    localparam int PROG_LSB = 3;

    // ------------------------------------------------------------
    // Control register field positions and reset value
    // ------------------------------------------------------------
    localparam int CTL_PGM_SPACE = 7;
    localparam int CTL_CFG_SPACE = 6;
    localparam int CTL_ROW_ERASE = 4;
    localparam int CTL_WR_ERROR = 3;
    localparam int CTL_WR_ENABLE = 2;
    localparam int CTL_WR_START = 1;
    localparam logic [7:0] CTL_RESET = 8'h00;

    // ------------------------------------------------------------
    // Unlock codes and data reset values
    // ------------------------------------------------------------
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] HOLD_RESET = 8'hFF;
    localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 25000;
    localparam int LONG_WRITE_US = 2000;
    localparam int LONG_WRITE_CYCLES = (LONG_WRITE_US * CLK_KHZ) / 1000;

    // ------------------------------------------------------------
    // Pointer update modes of a table operation
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PTR_KEEP = 2'b00,
        PTR_POST_INC = 2'b01,
        PTR_POST_DEC = 2'b10,
        PTR_PRE_INC = 2'b11
    } ptr_mode_t;

    typedef enum logic [1:0] {
        UL_IDLE = 2'b00,
        UL_FIRST = 2'b01,
        UL_ARMED = 2'b11
    } unlock_state_t;

    typedef enum logic [1:0] {
        LW_IDLE = 2'b00,
        LW_ERASE = 2'b01,
        LW_PROG = 2'b11
    } long_write_state_t;

endpackage : program_flash_pkg

// ---- dv/program_flash_self_update_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
module program_flash_self_update_monitor #(
    parameter int LONG_WRITE_CYCLES = 20
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic por_n_i,
    input wire logic table_read_op_i,
    input wire logic table_write_op_i,
    input wire logic [1:0] ptr_mode_i,
    input wire logic nvm_control_wr_i,
    input wire logic [7:0] nvm_control_wdata_i,
    input wire logic [21:0] table_pointer_o,
    input wire logic [7:0] table_latch_o,
    input wire logic [7:0] nvm_control_reg_o,
    input wire logic core_stall_o,
    input wire logic flash_rd_en_o,
    input wire logic [20:0] flash_rd_word_addr_o,
    input wire logic [15:0] flash_rd_data_i,
    input wire logic flash_erase_o,
    input wire logic flash_prog_o,
    input wire logic [21:0] flash_op_addr_o,
    input wire logic [63:0] flash_prog_data_o
);
    // ----------------
    // Helper state
    // ----------------
    int stall_cnt;
    logic [2:0] wr_idx_r;
    logic [7:0] rd_byte_r;
    wire logic [7:0] hold_sel = flash_prog_data_o[{wr_idx_r, 3'h0} +: 8];
    always_ff @(posedge ref_clk_i) begin
        stall_cnt <= (!rst_n_i || !por_n_i || !core_stall_o) ? 0 : stall_cnt + 1;
        wr_idx_r <= table_pointer_o[2:0];
        rd_byte_r <= table_pointer_o[0] ? flash_rd_data_i[15:8] : flash_rd_data_i[7:0];
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i || !por_n_i);
    sequence seq_long_end;
        $fell(core_stall_o);
    endsequence
    sequence seq_bad_start;
        nvm_control_wr_i && nvm_control_wdata_i[1] && !nvm_control_wdata_i[2] && !core_stall_o;
    endsequence
    stall_len_a: assert property (seq_long_end |-> stall_cnt == LONG_WRITE_CYCLES)
        else $error("stall length wrong");
    stall_bound_a: assert property (core_stall_o |-> stall_cnt < LONG_WRITE_CYCLES)
        else $error("stall overrun");
    start_strobe_a: assert property ($rose(core_stall_o) |-> flash_erase_o != flash_prog_o)
        else $error("no single strobe at stall start");
    erase_align_a: assert property (flash_erase_o |-> core_stall_o && flash_op_addr_o[5:0] == 6'h00)
        else $error("erase address unaligned");
    prog_align_a: assert property (flash_prog_o |-> core_stall_o && flash_op_addr_o[2:0] == 3'h0)
        else $error("program address unaligned");
    end_clear_a: assert property (seq_long_end |-> nvm_control_reg_o[1] == 1'b0 && !nvm_control_reg_o[4])
        else $error("control bits left set");
    no_enable_a: assert property (seq_bad_start |=> !core_stall_o && !flash_erase_o && !flash_prog_o)
        else $error("start with writes disabled");
    read_byte_a: assert property (table_read_op_i && !core_stall_o && ptr_mode_i != 2'h3 |->
        flash_rd_en_o && flash_rd_word_addr_o == table_pointer_o[21:1] ##1 table_latch_o == rd_byte_r)
        else $error("wrong read byte");
    hold_write_a: assert property (table_write_op_i && !core_stall_o && ptr_mode_i != 2'h3 |=>
        hold_sel == $past(table_latch_o) && !flash_prog_o)
        else $error("holding register missed");
endmodule : program_flash_self_update_monitor
bind program_flash_self_update program_flash_self_update_monitor #(.LONG_WRITE_CYCLES(LONG_WRITE_CYCLES)) i_mon (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .table_read_op_i(table_read_op_i),
    .table_write_op_i(table_write_op_i), .ptr_mode_i(ptr_mode_i), .nvm_control_wr_i(nvm_control_wr_i),
    .nvm_control_wdata_i(nvm_control_wdata_i), .table_pointer_o(table_pointer_o), .table_latch_o(table_latch_o),
    .nvm_control_reg_o(nvm_control_reg_o), .core_stall_o(core_stall_o), .flash_rd_en_o(flash_rd_en_o),
    .flash_rd_word_addr_o(flash_rd_word_addr_o), .flash_rd_data_i(flash_rd_data_i), .flash_erase_o(flash_erase_o),
    .flash_prog_o(flash_prog_o), .flash_op_addr_o(flash_op_addr_o), .flash_prog_data_o(flash_prog_data_o));
`default_nettype wire

// ---- dv/flash_array_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module flash_array_model (
    input wire logic ref_clk_i,
    input wire logic flash_rd_en_i,
    input wire logic [20:0] flash_rd_word_addr_i,
    output logic [15:0] flash_rd_data_o,
    input wire logic flash_erase_i,
    input wire logic flash_prog_i,
    input wire logic [21:0] flash_op_addr_i,
    input wire logic [63:0] flash_prog_data_i
);
    // ----------------
    // Array word pattern and strobe log
    // ----------------
    int erase_cnt = 0;
    int prog_cnt = 0;
    logic [63:0] last_data = 64'h0;
    logic [15:0] idle_r = 16'h5A3C;
    // Churns when unread so stale words never pass as data
    always @(posedge ref_clk_i) idle_r <= ~idle_r;
    assign flash_rd_data_o = flash_rd_en_i ? {~flash_rd_word_addr_i[7:0], flash_rd_word_addr_i[7:0]} : idle_r;
    always @(posedge ref_clk_i) begin
        if (flash_erase_i) begin
            erase_cnt <= erase_cnt + 1;
        end
        if (flash_prog_i) begin
            prog_cnt <= prog_cnt + 1;
            last_data <= flash_prog_data_i;
        end
    end
endmodule : flash_array_model
`default_nettype wire

// ---- dv/program_flash_self_update_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module program_flash_self_update_tb;
    localparam int STALL_N = 20;
    localparam int K_PTR = 0, K_LAT = 1, K_CTL = 2, K_UNL = 3, K_RD = 4, K_TW = 5;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic por_n_i = 1'b0;
    logic rd_op = 1'b0, tw_op = 1'b0, ptr_wr = 1'b0, lat_wr = 1'b0, ctl_wr = 1'b0, unl_wr = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [21:0] ptr_d = 22'h000000;
    logic [7:0] lat_d = 8'h00, ctl_d = 8'h00, unl_d = 8'h00;
    logic [21:0] ptr_q, op_addr;
    logic [7:0] latch_q, ctl_q;
    logic err_q, stall, rd_en, erase, prog;
    logic [20:0] rd_addr;
    logic [15:0] rd_data;
    logic [63:0] prog_data;
    int fails = 0;
    int comparisons = 0;
    wire [63:0] act = {60'h0, stall, prog, erase, ctl_q[1]};
    always #20 ref_clk_i = ~ref_clk_i;
    program_flash_self_update #(.LONG_WRITE_CYCLES(STALL_N)) i_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .por_n_i(por_n_i), .table_read_op_i(rd_op),
        .table_write_op_i(tw_op), .ptr_mode_i(mode), .table_pointer_wr_i(ptr_wr), .table_pointer_wdata_i(ptr_d),
        .table_latch_wr_i(lat_wr), .table_latch_wdata_i(lat_d), .nvm_control_wr_i(ctl_wr),
        .nvm_control_wdata_i(ctl_d), .nvm_unlock_wr_i(unl_wr), .nvm_unlock_wdata_i(unl_d),
        .table_pointer_o(ptr_q), .table_latch_o(latch_q), .nvm_control_reg_o(ctl_q), .write_error_flag_o(err_q),
        .core_stall_o(stall), .flash_rd_en_o(rd_en), .flash_rd_word_addr_o(rd_addr), .flash_rd_data_i(rd_data),
        .flash_erase_o(erase), .flash_prog_o(prog), .flash_op_addr_o(op_addr), .flash_prog_data_o(prog_data));
    flash_array_model i_flash (.ref_clk_i(ref_clk_i), .flash_rd_en_i(rd_en), .flash_rd_word_addr_i(rd_addr),
        .flash_rd_data_o(rd_data), .flash_erase_i(erase), .flash_prog_i(prog), .flash_op_addr_i(op_addr),
        .flash_prog_data_i(prog_data));
    // ----------------
    // Core access tasks
    // ----------------
    task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Idle cycle after each access keeps strobes single pulses
    task drive(input int k, input logic [21:0] d, input logic [1:0] m);
        @(negedge ref_clk_i);
        mode = m;
        case (k)
            K_PTR: begin ptr_wr = 1'b1; ptr_d = d; end
            K_LAT: begin lat_wr = 1'b1; lat_d = d[7:0]; end
            K_CTL: begin ctl_wr = 1'b1; ctl_d = d[7:0]; end
            K_UNL: begin unl_wr = 1'b1; unl_d = d[7:0]; end
            K_RD: rd_op = 1'b1;
            default: tw_op = 1'b1;
        endcase
        @(negedge ref_clk_i);
        {ptr_wr, lat_wr, ctl_wr, unl_wr, rd_op, tw_op} = 6'h00;
    endtask : drive
    task start(input logic [7:0] c);
        drive(K_UNL, 22'h000055, 2'h0);
        drive(K_UNL, 22'h0000AA, 2'h0);
        drive(K_CTL, {14'h0000, c}, 2'h0);
    endtask : start
    task wait_stall(output int n);
        n = 0;
        while (stall === 1'b1 && n < 1000) begin
            @(negedge ref_clk_i);
            n++;
        end
    endtask : wait_stall
    task end_sim;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    // ----------------
    // Scenarios
    // ----------------
    task read_test;
        drive(K_PTR, 22'h000101, 2'h0);
        for (int i = 0; i < 4; i++) begin
            drive(K_RD, 22'h000000, i[1:0]);
            chk("table_latch", {56'h0, latch_q}, {56'h0, (i < 2 ? 8'h7F : 8'h81)});
            chk("table_pointer", {42'h0, ptr_q}, {42'h0, 22'h000101 + 22'(i[0])});
        end
        $display("read_test done");
    endtask : read_test
    task erase_test;
        int n;
        drive(K_PTR, 22'h00127F, 2'h0);
        start(8'h96);
        chk("erase strobe", {62'h0, stall, erase}, 64'h3);
        chk("erase address", {42'h0, op_addr}, 64'h1240);
        chk("start bit", {63'h0, ctl_q[1]}, 64'h1);
        wait_stall(n);
        chk("erase stall", n, STALL_N);
        chk("bits cleared", {56'h0, ctl_q & 8'h12}, 64'h0);
        chk("erase count", i_flash.erase_cnt, 1);
        $display("erase_test done");
    endtask : erase_test
    task prog_test;
        int n;
        logic [63:0] exp_d;
        drive(K_PTR, 22'h000200, 2'h0);
        for (int i = 0; i < 8; i++) begin
            drive(K_LAT, 22'(16 + i), 2'h0);
            drive(K_TW, 22'h000000, 2'h1);
            exp_d[8*i +: 8] = 8'h10 + i[7:0];
        end
        chk("holding regs", prog_data, exp_d);
        chk("array untouched", i_flash.prog_cnt, 0);
        drive(K_PTR, 22'h000205, 2'h0);
        start(8'h86);
        chk("prog strobe", {62'h0, stall, prog}, 64'h3);
        chk("prog address", {42'h0, op_addr}, 64'h200);
        wait_stall(n);
        chk("prog stall", n, STALL_N);
        chk("prog data", i_flash.last_data, exp_d);
        chk("start bit", {63'h0, ctl_q[1]}, 64'h0);
        $display("prog_test done");
    endtask : prog_test
    task refuse_test;
        drive(K_CTL, 22'h000086, 2'h0);
        chk("no unlock", act, 64'h0);
        drive(K_UNL, 22'h000055, 2'h0);
        drive(K_UNL, 22'h0000AA, 2'h0);
        drive(K_LAT, 22'h000000, 2'h0);
        drive(K_CTL, 22'h000086, 2'h0);
        chk("broken unlock", act, 64'h0);
        drive(K_UNL, 22'h0000AA, 2'h0);
        drive(K_UNL, 22'h000055, 2'h0);
        drive(K_CTL, 22'h000086, 2'h0);
        chk("swapped unlock", act, 64'h0);
        start(8'h82);
        chk("writes disabled", act, 64'h0);
        $display("refuse_test done");
    endtask : refuse_test
    task error_test;
        drive(K_PTR, 22'h000400, 2'h0);
        start(8'h96);
        repeat (3) @(negedge ref_clk_i);
        rst_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        chk("error flag", {62'h0, err_q, stall}, 64'h2);
        chk("space kept", {63'h0, ctl_q[7]}, 64'h1);
        por_n_i = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        por_n_i = 1'b1;
        chk("error cleared", {63'h0, err_q}, 64'h0);
        $display("error_test done");
    endtask : error_test
    initial begin
        #(40 * 4000);
        fails++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end
    initial begin
        repeat (20) @(negedge ref_clk_i);
        rst_n_i = 1'b1;
        por_n_i = 1'b1;
        read_test();
        erase_test();
        prog_test();
        refuse_test();
        error_test();
        end_sim();
    end
endmodule : program_flash_self_update_tb
`default_nettype wire
